// *** logic/dual_down_counter_timer.sv ***
/*
  dual 8-bit down counter with 16-bit cascade, nibble-wide count reads,
  run/stop synchronised to the input clock falling edge, gated timer output.
  assumes an AHB-Lite master on hclk, pins arriving asynchronously.
*/
// Our own choices: the register offsets and register access over AHB-Lite.
// Functional notes
// - a run bit write takes effect only at the next input clock falling edge.
// - a running channel decrements by one per input clock, chan1 in cascade by one per chan0 wrap.
// - after run is cleared the channel decrements once more then holds.
// - the run bit reads one until the channel has really stopped.
// - event counter mode also waits for a pin edge, without one run state holds.
// - the timer output is gated by its enable asynchronously to the timer clock.
// - the fast oscillator is off after reset.
// - the event clock pin also feeds the general input port.
`timescale 1ns/1ns
`default_nettype none
module dual_down_counter_timer
  import dual_timer_pkg::*;
#(
  parameter int DIV_HALF = 25
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fast_osc_clk,
  output logic fast_osc_enable,
  input wire logic event_clock_input_pin,
  output logic event_pin_level,
  output logic timer_output_signal
);
  logic [1:0] run_req, next_run_req;
  logic [1:0] running, next_running;
  logic cascade, next_cascade;
  logic oe, next_oe;
  logic osc_on, next_osc_on;
  clk_src_e src, next_src;
  logic [7:0] count0, next_count0;
  logic [7:0] count1, next_count1;
  logic [3:0] snap_hi0, next_snap_hi0;
  logic [3:0] snap_hi1, next_snap_hi1;
  logic [7:0] snap1, next_snap1;
  logic [1:0] fast_s, next_fast_s;
  logic [1:0] evt_s, next_evt_s;
  logic sel_prev, next_sel_prev;
  logic [7:0] div_cnt, next_div_cnt;
  logic div_clk, next_div_clk;
  logic timer_output_signal_q, next_timer_output_signal_q;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic next_evt_level;
  logic sel_lvl, fall, uf0, dec1;
  logic addr_ok;
  logic [7:0] rd_addr;

  // unused request fields
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8]};

  // zero-wait slave, frozen with the clock enable
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign fast_osc_enable = osc_on;
  // output gated by plain logic, not re-timed to the timer clock
  assign timer_output_signal = timer_output_signal_q & oe;

  // input clock selection and falling edge
  always_comb begin
    unique case (src)
      SRC_DIV: sel_lvl = div_clk;
      SRC_FAST: sel_lvl = fast_s[1] & osc_on;
      SRC_EVENT: sel_lvl = evt_s[1];
      default: sel_lvl = 1'b0;
    endcase
    fall = sel_prev & ~sel_lvl;
    uf0 = fall && running[0] && (count0 == 8'h00);
    dec1 = cascade ? (uf0 && running[1]) : (fall && running[1]);
    addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
    rd_addr = haddr[7:0];
  end

  // next-state computation
  always_comb begin
    next_run_req = run_req;
    next_running = running;
    next_cascade = cascade;
    next_oe = oe;
    next_osc_on = osc_on;
    next_src = src;
    next_count0 = count0;
    next_count1 = count1;
    next_snap_hi0 = snap_hi0;
    next_snap_hi1 = snap_hi1;
    next_snap1 = snap1;
    next_fast_s = {fast_s[0], fast_osc_clk};
    next_evt_s = {evt_s[0], event_clock_input_pin};
    next_evt_level = evt_s[1];
    next_sel_prev = sel_lvl;
    next_div_cnt = div_cnt + 8'h01;
    next_div_clk = div_clk;
    next_timer_output_signal_q = timer_output_signal_q;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = hrdata;
    // internal divided clock
    if (div_cnt >= 8'(DIV_HALF - 1)) begin
      next_div_cnt = 8'h00;
      next_div_clk = ~div_clk;
    end
    // run state changes only at an input clock falling edge
    if (fall) begin
      if (running[0]) begin
        next_count0 = count0 - 8'h01;
      end
      next_running[0] = run_req[0];
      next_running[1] = cascade ? run_req[0] : run_req[1];
    end
    if (dec1) begin
      next_count1 = count1 - 8'h01;
    end
    // output toggles on underflow of the active counter
    if (cascade ? (dec1 && count1 == 8'h00) : uf0) begin
      next_timer_output_signal_q = ~timer_output_signal_q;
    end
    // data phase of a write
    if (wr_pend) begin
      unique case (wr_addr)
        CTRL_OFS: begin
          next_run_req = hwdata[RUN1_BIT:RUN0_BIT];
          next_cascade = hwdata[CASC_BIT];
          next_oe = hwdata[OE_BIT];
          next_osc_on = hwdata[OSC_BIT];
          next_src = clk_src_e'(hwdata[SRC_LSB+1:SRC_LSB]);
          // a source switch must not look like a falling edge
          if (hwdata[SRC_LSB+1:SRC_LSB] != src) begin
            next_sel_prev = 1'b0;
          end
        end
        LOAD0_OFS: if (!running[0]) next_count0 = hwdata[7:0];
        LOAD1_OFS: if (!running[1]) next_count1 = hwdata[7:0];
        default: next_wr_addr = wr_addr;
      endcase
    end
    // address phase
    if (addr_ok) begin
      next_wr_pend = hwrite;
      next_wr_addr = rd_addr;
      if (!hwrite) begin
        next_hrdata = RDATA_RST;
        unique case (rd_addr)
          CTRL_OFS: begin
            next_hrdata[RUN1_BIT:RUN0_BIT] = run_req | running;
            next_hrdata[CASC_BIT] = cascade;
            next_hrdata[OE_BIT] = oe;
            next_hrdata[OSC_BIT] = osc_on;
            next_hrdata[SRC_LSB+1:SRC_LSB] = src;
          end
          LOAD0_OFS: next_hrdata[7:0] = count0;
          LOAD1_OFS: next_hrdata[7:0] = count1;
          C0_LO_OFS: begin
            next_hrdata[3:0] = count0[3:0];
            next_snap_hi0 = count0[7:4];
            next_snap1 = count1;
          end
          C0_HI_OFS: next_hrdata[3:0] = snap_hi0;
          C1_LO_OFS: begin
            next_hrdata[3:0] = cascade ? snap1[3:0] : count1[3:0];
            next_snap_hi1 = cascade ? snap1[7:4] : count1[7:4];
          end
          C1_HI_OFS: next_hrdata[3:0] = snap_hi1;
          STAT_OFS: next_hrdata[1:0] = running;
          default: next_hrdata = RDATA_RST;
        endcase
      end
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_req <= 2'b00;
      running <= 2'b00;
      cascade <= 1'b0;
      oe <= 1'b0;
      osc_on <= 1'b0;
      src <= SRC_DIV;
      count0 <= COUNT_RST;
      count1 <= COUNT_RST;
      snap_hi0 <= 4'h0;
      snap_hi1 <= 4'h0;
      snap1 <= 8'h00;
      fast_s <= 2'b00;
      evt_s <= 2'b00;
      event_pin_level <= 1'b0;
      sel_prev <= 1'b0;
      div_cnt <= 8'h00;
      div_clk <= 1'b0;
      timer_output_signal_q <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= RDATA_RST;
    end else if (ce) begin
      run_req <= next_run_req;
      running <= next_running;
      cascade <= next_cascade;
      oe <= next_oe;
      osc_on <= next_osc_on;
      src <= next_src;
      count0 <= next_count0;
      count1 <= next_count1;
      snap_hi0 <= next_snap_hi0;
      snap_hi1 <= next_snap_hi1;
      snap1 <= next_snap1;
      fast_s <= next_fast_s;
      evt_s <= next_evt_s;
      event_pin_level <= next_evt_level;
      sel_prev <= next_sel_prev;
      div_cnt <= next_div_cnt;
      div_clk <= next_div_clk;
      timer_output_signal_q <= next_timer_output_signal_q;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // checks on run control, counting and reads
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  start_wait_a: assert property (ce && !fall |=> running == $past(running))
    else $error("run state changed without an input clock edge");
  step_down_a: assert property (ce && fall && running[0] |=> count0 == $past(count0) - 8'h01)
    else $error("chan0 did not step down by one");
  stop_decr_a: assert property (ce && fall && running[0] && !run_req[0] && !wr_pend
    |=> !running[0] && count0 == $past(count0) - 8'h01)
    else $error("chan0 stop without final decrement");
  run_read_a: assert property (ce && addr_ok && !hwrite && rd_addr == CTRL_OFS && running[0]
    |=> hrdata[RUN0_BIT])
    else $error("run bit read zero while still running");
  event_hold_a: assert property (ce && src == SRC_EVENT && !(sel_prev && !evt_s[1])
    |=> running == $past(running))
    else $error("event mode run state changed without pin edge");
  gate_off_a: assert property (!oe |-> !timer_output_signal)
    else $error("timer output active while disabled");
  osc_off_a: assert property (ce && !osc_on && src == SRC_FAST |=> !fall)
    else $error("fast source ticked with oscillator off");
  pin_level_a: assert property (ce ##1 ce ##1 ce |=> event_pin_level == $past(event_clock_input_pin, 3))
    else $error("event pin level not passed to input port");
  snap_high_a: assert property (ce && addr_ok && !hwrite && rd_addr == C0_LO_OFS
    |=> snap_hi0 == $past(count0[7:4]))
    else $error("high nibble not captured on low read");
  cascade_a: assert property (ce && cascade && uf0 && running[1]
    |=> count1 == $past(count1) - 8'h01)
    else $error("chan1 did not follow chan0 wrap");

  stop_cov_c: cover property (running[0] && !run_req[0] ##1 !running[0]);
  casc_cov_c: cover property (cascade && dec1);
  event_cov_c: cover property (src == SRC_EVENT && fall && running[0]);
  timer_output_signal_cov_c: cover property (oe && $rose(timer_output_signal_q));
endmodule
`default_nettype wire

// *** logic/dual_timer_pkg.sv ***
/*
  constants for the dual 8-bit down-counting timer: register map,
  control field positions, reset values, clock sources, timing counts.
  assumes a 50 MHz hclk and an AHB-Lite register bus of 32-bit words.
*/
`default_nettype none
package dual_timer_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOAD0_OFS = 8'h04;
  localparam logic [7:0] LOAD1_OFS = 8'h08;
  localparam logic [7:0] C0_LO_OFS = 8'h10;
  localparam logic [7:0] C0_HI_OFS = 8'h14;
  localparam logic [7:0] C1_LO_OFS = 8'h18;
  localparam logic [7:0] C1_HI_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h20;
  // control field positions
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int CASC_BIT = 2;
  localparam int OE_BIT = 3;
  localparam int OSC_BIT = 4;
  localparam int SRC_LSB = 5;
  // reset values
  localparam logic [7:0] COUNT_RST = 8'hff;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // input clock source select
  typedef enum logic [1:0] {
    SRC_DIV = 2'b00,
    SRC_FAST = 2'b01,
    SRC_EVENT = 2'b11
  } clk_src_e;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // software read windows, longest times rounded down
  localparam int HCLK_KHZ = 50_000;
  localparam int LOHI_WINDOW_US = 730;
  localparam int SEQ_WINDOW_US = 1460;
  localparam int LOHI_WINDOW_CYC = (LOHI_WINDOW_US * HCLK_KHZ) / 1000;
  localparam int SEQ_WINDOW_CYC = (SEQ_WINDOW_US * HCLK_KHZ) / 1000;
endpackage
`default_nettype wire

// *** verification/dual_down_counter_timer_tb.sv ***
/*
  self-checking bench for the dual down counter timer: bus reads queued
  and compared by a monitor, event pin ticks, cascade and output gating.
  assumes the timer answers with zero wait states while ce is high.
*/
`timescale 1ns/1ns
`default_nettype none
module dual_down_counter_timer_tb import dual_timer_pkg::*;;
  localparam int LIMIT = 3000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pin = 1'b0;
  logic ce = 1'b1;
  logic fast_clk = 1'b0;
  logic dph_rd = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic fast_osc_enable;
  logic event_pin_level;
  logic timer_output_signal;
  logic [31:0] exp_q[$];
  logic [7:0] v = 8'h2f;
  int errors = 0;
  int compares = 0;
  int cyc = 0;

  // 50 MHz bus clock
  always #10 hclk = ~hclk;

  dual_down_counter_timer #(.DIV_HALF(2)) i_dual_down_counter_timer (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fast_osc_clk(fast_clk), .fast_osc_enable(fast_osc_enable),
    .event_clock_input_pin(pin), .event_pin_level(event_pin_level),
    .timer_output_signal(timer_output_signal)
  );

  // random load values
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic summarize();
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    dph_rd <= ~w;
    wait_rdy();
    dph_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // one pulse on the event pin, falling edge gives the tick
  task automatic tick();
    pin <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_pin(event_pin_level, 1'b1);
    pin <= 1'b0;
    repeat (6) @(posedge hclk);
    chk_pin(event_pin_level, 1'b0);
  endtask

  // monitor: compares read data, runs the fast oscillator pin, cuts a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc[0]) begin
      fast_clk <= ~fast_clk; // quarter of hclk
    end
    if (dph_rd && hreadyout === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk_pin(hresp, 1'b0);
    end
    if (cyc == LIMIT) begin
      errors++;
      summarize();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    chk_pin(fast_osc_enable, 1'b0);
    rd(8'h24, 32'h0);
    wr(CTRL_OFS, 32'h10);
    @(posedge hclk);
    chk_pin(fast_osc_enable, 1'b1);
    v = lfsr(v);
    wr(LOAD0_OFS, {24'h0, v});
    rd(LOAD0_OFS, {24'h0, v});
    wr(CTRL_OFS, 32'h61);
    rd(STAT_OFS, 32'h0);
    rd(CTRL_OFS, 32'h61);
    tick();
    rd(STAT_OFS, 32'h1);
    for (int i = 0; i < 3; i++) begin
      rd(C0_LO_OFS, {28'h0, v[3:0]});
      rd(C0_HI_OFS, {28'h0, v[7:4]});
      tick();
      v = v - 8'h1;
    end
    // clock enable low: a pin pulse goes unseen and nothing moves
    ce <= 1'b0;
    pin <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_pin(event_pin_level, 1'b0);
    pin <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    rd(C0_LO_OFS, {28'h0, v[3:0]});
    wr(CTRL_OFS, 32'h60);
    rd(CTRL_OFS, 32'h61);
    rd(STAT_OFS, 32'h1);
    tick();
    v = v - 8'h1;
    rd(STAT_OFS, 32'h0);
    rd(CTRL_OFS, 32'h60);
    tick();
    rd(LOAD0_OFS, {24'h0, v});
    // cascade: chan0 wraps and borrows from chan1
    wr(LOAD0_OFS, 32'h0);
    wr(LOAD1_OFS, 32'h35);
    wr(CTRL_OFS, 32'h65);
    tick();
    rd(C0_LO_OFS, 32'h0);
    tick();
    rd(C0_HI_OFS, 32'h0);
    rd(C1_LO_OFS, 32'h5);
    rd(C1_HI_OFS, 32'h3);
    rd(C0_LO_OFS, 32'hf);
    rd(C0_HI_OFS, 32'hf);
    rd(C1_LO_OFS, 32'h4);
    rd(C1_HI_OFS, 32'h3);
    wr(CTRL_OFS, 32'h64);
    tick();
    // output gating after a chan0 underflow
    wr(LOAD0_OFS, 32'h1);
    wr(CTRL_OFS, 32'h69);
    tick();
    tick();
    tick();
    chk_pin(timer_output_signal, 1'b1);
    wr(CTRL_OFS, 32'h61);
    @(posedge hclk);
    chk_pin(timer_output_signal, 1'b0);
    // fast source: no edges while the oscillator is off, so the stop waits
    wr(CTRL_OFS, 32'h20);
    repeat (20) @(posedge hclk);
    rd(STAT_OFS, 32'h1);
    rd(CTRL_OFS, 32'h21);
    wr(CTRL_OFS, 32'h30);
    repeat (20) @(posedge hclk);
    chk_pin(fast_osc_enable, 1'b1);
    rd(STAT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h31);
    repeat (20) @(posedge hclk);
    rd(STAT_OFS, 32'h1);
    wr(CTRL_OFS, 32'h30);
    repeat (20) @(posedge hclk);
    rd(STAT_OFS, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
